// ===== rtl/fault_resp_pkg.sv
// constants for the fault response controller: register map, fields, codes, timing
// assumes a single 200 MHz clock and a plain strobe register port
package fault_resp_pkg;
  localparam int CLK_MHZ = 200;
  localparam int UNIT_NS = 1000;
  localparam int UNIT_CYC = (UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int RETRY_WAIT_NS = 10000;
  localparam int RETRY_WAIT_CYC = (RETRY_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_TRIES = 8'h10;
  localparam logic [7:0] ADDR_CFG0 = 8'h20;

  localparam int CTRL_OP_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_OP_RST = 1'b1;
  localparam int STATE_SHUT_LSB = 0;
  localparam int STATE_LATCH_LSB = 8;
  localparam int STATE_FAULT_LSB = 16;
  localparam int STATE_EN_BIT = 24;

  localparam int CFG_DLY_LSB = 0;
  localparam int CFG_RETRY_LSB = 3;
  localparam int CFG_CODE_LSB = 6;
  localparam logic [7:0] CFG_RST = 8'hC0;

  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  typedef enum logic [1:0] {CH_IDLE, CH_DELAY, CH_WAIT, CH_LATCH} ch_state_e;
endpackage

// ===== rtl/fault_channel.sv
// response sequencer for one monitored fault
// assumes fault_i is already synchronised; clear_i is a one-cycle pulse
`timescale 1ns/1ps
module fault_channel import fault_resp_pkg::*; #(
  parameter int UNIT = UNIT_CYC,
  parameter int WAIT = RETRY_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // fault and config
  input wire logic fault_i,
  input wire logic [7:0] cfg_i,
  input wire logic clear_i,
  // response
  output logic shut_o,
  output logic latch_o,
  output logic event_o,
  output logic [2:0] tries_o
);
  if (UNIT < 1 || WAIT < 1 || 7 * UNIT >= (1 << CNT_W) || WAIT >= (1 << CNT_W)) begin : g_chk
    $error("fault_channel: delay unit or retry wait does not fit the counter");
  end

  typedef struct packed {
    ch_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [2:0] tries;
    logic fault_q;
    logic evt;
  } ch_s;

  ch_s s;
  ch_s next_s;
  logic [1:0] code;
  logic [2:0] retry;
  logic [CNT_W-1:0] limit;
  logic give_up;

  assign code = cfg_i[CFG_CODE_LSB +: 2];
  assign retry = cfg_i[CFG_RETRY_LSB +: 3];
  assign limit = CNT_W'(32'(cfg_i[CFG_DLY_LSB +: 3]) * UNIT);
  // no retry left: latch off instead of waiting
  assign give_up = retry == RETRY_NONE || (retry != RETRY_FOREVER && s.tries >= retry);

  always_comb begin
    next_s = s;
    next_s.fault_q = fault_i;
    next_s.evt = fault_i & ~s.fault_q & (code != RESP_IGNORE);
    if (clear_i) begin
      next_s.state = CH_IDLE;
      next_s.cnt = '0;
      next_s.tries = '0;
    end else begin
      case (s.state)
        CH_IDLE: begin
          next_s.cnt = '0;
          if (fault_i) begin
            case (code)
              RESP_DELAY: next_s.state = CH_DELAY;
              RESP_RETRY: next_s.state = give_up ? CH_LATCH : CH_WAIT;
              RESP_LATCH: next_s.state = CH_LATCH;
              default: next_s.state = CH_IDLE;
            endcase
          end
        end
        CH_DELAY: begin
          if (!fault_i) begin
            next_s.state = CH_IDLE;
            next_s.cnt = '0;
          end else if (s.cnt >= limit) begin
            next_s.state = give_up ? CH_LATCH : CH_WAIT;
            next_s.cnt = '0;
          end else begin
            next_s.cnt = s.cnt + 1'b1;
          end
        end
        CH_WAIT: begin
          if (s.cnt >= CNT_W'(WAIT - 1)) begin
            next_s.state = CH_IDLE;
            next_s.cnt = '0;
            next_s.tries = (s.tries == 3'h7) ? s.tries : s.tries + 1'b1;
          end else begin
            next_s.cnt = s.cnt + 1'b1;
          end
        end
        CH_LATCH: next_s.state = CH_LATCH;
        default: next_s.state = CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s <= '{state: CH_IDLE, cnt: '0, tries: '0, fault_q: 1'b0, evt: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign shut_o = s.state == CH_WAIT || s.state == CH_LATCH;
  assign latch_o = s.state == CH_LATCH;
  assign event_o = s.evt;
  assign tries_o = s.tries;
endmodule

// ===== rtl/fault_response_controller.sv
// fault response controller: per-fault sequencers, output enable, registers, interrupt
// assumes fault and control pins are asynchronous; register port on clk_sys_i
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module fault_response_controller import fault_resp_pkg::*; #(
  parameter int NUM_FAULTS = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // pins
  input wire logic [NUM_FAULTS-1:0] fault_i,
  input wire logic ctrl_pin_i,
  // outputs
  output logic out_en_o,
  output logic irq_o
);
  localparam int N = NUM_FAULTS;

  // the state readback packs eight bits per field
  if (N < 1 || N > 8) begin : g_chk
    $error("fault_response_controller: NUM_FAULTS must be 1 to 8");
  end

  typedef struct packed {
    logic [N-1:0] fault_m;
    logic [N-1:0] fault_s;
    logic pin_m;
    logic pin_s;
    logic op;
    logic en_q;
    logic [N-1:0] mask;
    logic [N-1:0] status;
    logic [N-1:0][7:0] cfg;
    logic [31:0] rdata;
    logic out_en;
    logic irq;
  } top_s;

  top_s s;
  top_s next_s;

  // channel hookup
  logic [N-1:0] ch_clear;
  logic [N-1:0] ch_shut;
  logic [N-1:0] ch_latch;
  logic [N-1:0] ch_event;
  logic [N-1:0][2:0] ch_tries;

  // decoded requests
  logic en_now;
  logic cycle_on;
  logic clear_cmd;
  logic [N-1:0] w1c;
  logic [N-1:0] cfg_hit;

  assign en_now = s.pin_s & s.op;
  assign cycle_on = en_now & ~s.en_q;
  assign clear_cmd = wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_CLEAR_BIT];
  assign w1c = (wr_i && addr_i == ADDR_STATUS) ? wdata_i[N-1:0] : '0;

  // faults are cleared one by one through status, or all at once
  assign ch_clear = w1c | {N{clear_cmd | cycle_on}};

  for (genvar i = 0; i < N; i++) begin : g_ch
    assign cfg_hit[i] = wr_i && addr_i == 8'(ADDR_CFG0 + 8'(4 * i));

    // each fault gets its own unit, doubling per index
    fault_channel #(
      .UNIT(UNIT_CYC << i),
      .WAIT(RETRY_WAIT_CYC)
    ) u_ch (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .fault_i(s.fault_s[i]),
      .cfg_i(s.cfg[i]),
      .clear_i(ch_clear[i]),
      .shut_o(ch_shut[i]),
      .latch_o(ch_latch[i]),
      .event_o(ch_event[i]),
      .tries_o(ch_tries[i])
    );
  end

  always_comb begin
    next_s = s;

    // pin synchronisers
    next_s.fault_m = fault_i;
    next_s.fault_s = s.fault_m;
    next_s.pin_m = ctrl_pin_i;
    next_s.pin_s = s.pin_m;
    next_s.en_q = en_now;

    // register writes
    if (wr_i && addr_i == ADDR_CTRL) begin
      next_s.op = wdata_i[CTRL_OP_BIT];
    end
    if (wr_i && addr_i == ADDR_MASK) begin
      next_s.mask = wdata_i[N-1:0];
    end
    for (int i = 0; i < N; i++) begin
      if (cfg_hit[i]) begin
        next_s.cfg[i] = wdata_i[7:0];
      end
    end

    // set beats clear in the same cycle
    next_s.status = (s.status & ~(w1c | {N{clear_cmd}})) | ch_event;

    // reads answer one cycle later, unmapped reads zero
    next_s.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        ADDR_CTRL: next_s.rdata[CTRL_OP_BIT] = s.op;
        ADDR_STATUS: next_s.rdata[N-1:0] = s.status;
        ADDR_MASK: next_s.rdata[N-1:0] = s.mask;
        ADDR_STATE: begin
          next_s.rdata[STATE_SHUT_LSB +: N] = ch_shut;
          next_s.rdata[STATE_LATCH_LSB +: N] = ch_latch;
          next_s.rdata[STATE_FAULT_LSB +: N] = s.fault_s;
          next_s.rdata[STATE_EN_BIT] = s.out_en;
        end
        ADDR_TRIES: next_s.rdata[3*N-1:0] = ch_tries;
        default: begin
          for (int i = 0; i < N; i++) begin
            if (addr_i == 8'(ADDR_CFG0 + 8'(4 * i))) begin
              next_s.rdata[7:0] = s.cfg[i];
            end
          end
        end
      endcase
    end

    // output runs while commanded on and no fault holds it off
    next_s.out_en = en_now & ~|ch_shut;
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s <= '0;
      s.op <= CTRL_OP_RST;
      s.cfg <= {N{CFG_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign out_en_o = s.out_en;
  assign irq_o = s.irq;

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  logic [N-1:0] code_delay;
  logic [N-1:0] code_retry;
  logic [N-1:0] code_latch;
  logic [N-1:0] dly_zero;
  for (genvar i = 0; i < N; i++) begin : g_code
    assign code_delay[i] = s.cfg[i][CFG_CODE_LSB +: 2] == RESP_DELAY;
    assign code_retry[i] = s.cfg[i][CFG_CODE_LSB +: 2] == RESP_RETRY;
    assign code_latch[i] = s.cfg[i][CFG_CODE_LSB +: 2] == RESP_LATCH;
    assign dly_zero[i] = s.cfg[i][CFG_DLY_LSB +: 3] == 3'h0;
  end

  a_delay_keeps_on: assert property (
    (en_now && !ch_shut[0] && code_delay[0] && !dly_zero[0] && $rose(s.fault_s[0]) && ch_clear == '0
      && !cfg_hit[0]) |=> !ch_shut[0] ##1 !ch_shut[0]
  ) else $error("output shut during delay window");

  a_delay_expiry: assert property (
    (code_delay[0] && dly_zero[0] && $rose(s.fault_s[0]) && !ch_shut[0] && ch_clear == '0 && !cfg_hit[0])
      ##1 (s.fault_s[0] && ch_clear == '0 && !cfg_hit[0]) |=> ch_shut[0]
  ) else $error("persisting fault not acted on at delay expiry");

  a_retry_shuts: assert property (
    (code_retry[0] && s.fault_s[0] && !ch_shut[0] && !ch_clear[0] && !cfg_hit[0]) |=> ch_shut[0] ##1 !out_en_o
  ) else $error("disable and retry did not shut the output");

  a_latch_sets: assert property (
    (code_latch[0] && s.fault_s[0] && !ch_clear[0]) |=> ch_latch[0]
  ) else $error("latching fault did not latch");

  a_latch_holds: assert property (
    (ch_latch[0] && !ch_clear[0]) |=> ch_latch[0]
  ) else $error("latched fault released without a clear");

  a_status_clears: assert property (
    (ch_latch[0] && w1c[0]) |=> !ch_latch[0] && ch_tries[0] == 3'h0
  ) else $error("status write one did not clear the fault");

  a_clear_cmd: assert property (
    clear_cmd |=> ch_latch == '0
  ) else $error("clear command left a fault latched");

  a_cycle_clears: assert property (
    (ch_latch != '0 && !s.en_q && en_now) |=> ch_latch == '0 ##1 ch_tries == '0
  ) else $error("off then on did not clear latched faults");

  a_counters_reset: assert property (
    ch_clear[0] |=> ch_tries[0] == 3'h0 && !ch_shut[0]
  ) else $error("clear left a counter or shutdown standing");

  a_shut_gates: assert property (
    (ch_shut != '0) |=> !out_en_o
  ) else $error("output enabled during shutdown");

  a_irq_level: assert property (
    irq_o == |(s.status & s.mask)
  ) else $error("interrupt out of step with status and mask");

  a_read_timing: assert property (
    (rd_i && addr_i == ADDR_MASK) |=> rdata_o[N-1:0] == $past(s.mask)
  ) else $error("read data not one cycle after strobe");

  c_latch_cleared: cover property (ch_latch[0] ##[1:50] !ch_latch[0]);
  // the retry wait is longer than the delay range of fault 0 may reach, so cover the moment it ends
  c_retry_resume: cover property (ch_shut[0] && code_retry[0] ##1 !ch_shut[0] && s.fault_s[0]);
  c_delay_ride: cover property (code_delay[0] && s.fault_s[0] && out_en_o ##[1:400] ch_shut[0]);
  c_irq_seen: cover property ($rose(irq_o));
endmodule

// ===== testbench/host_model.sv
// partner: management host on the register port, plus the on/off control pin
// assumes one caller at a time; every change is made just after a rising edge
`timescale 1ns/1ps
module host_model import fault_resp_pkg::*; (
  // clock
  input wire logic clk_sys_i,
  // register port
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [31:0] rdata_i,
  // control pin
  output logic pin_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    pin_o = 1'b0;
  end

  // control register with bit1 set is the clear faults command
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask

  // low then high again is the off-on restart
  task automatic pin(input logic v, input int hold);
    @(posedge clk_sys_i);
    pin_o <= v;
    repeat (hold) @(posedge clk_sys_i);
    #1;
  endtask
endmodule

// ===== testbench/tb_fault_response_controller.sv
// self-checking bench for the fault response controller, faults 0 and 1 exercised
// assumes package delay unit 200 cycles and retry wait 2000 cycles
`timescale 1ns/1ps
module tb_fault_response_controller import fault_resp_pkg::*; ();
  logic clk_sys_i;
  logic rst_i;
  logic [3:0] fault;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] v;
  logic wr;
  logic rd;
  logic pin;
  logic out_en;
  logic irq;
  int miscompares = 0;
  int compares = 0;
  int n;

  fault_response_controller #(.NUM_FAULTS(4)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .fault_i(fault), .ctrl_pin_i(pin),
    .out_en_o(out_en), .irq_o(irq));
  host_model host (.clk_sys_i(clk_sys_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata), .pin_o(pin));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out();
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_reg(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, v);
    chk_reg($sformatf("reg %h", a), e, v);
  endtask

  task automatic setf(input logic [3:0] f);
    @(posedge clk_sys_i);
    fault <= f;
  endtask

  // counts edges until the output enable shows val; a spent bound ends the run
  task automatic wait_en(input logic val, input int lim);
    n = 0;
    while (out_en !== val) begin
      if (n == lim) begin
        chk_bit("out_en wait", val, out_en);
        close_out();
      end
      @(posedge clk_sys_i);
      #1;
      n++;
    end
  endtask

  initial begin
    rst_i = 1'b1;
    fault = 4'h0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rchk(ADDR_CTRL, 32'h1);
    rchk(ADDR_CFG0, 32'hC0);
    rchk(ADDR_MASK, 32'h0);
    rchk(ADDR_STATUS, 32'h0);
    rchk(8'h3C, 32'h0);
    host.wr(ADDR_MASK, 32'hF);
    host.pin(1'b1, 0);
    wait_en(1'b1, 20);
    // latch-until-cleared released three different ways
    for (int k = 0; k < 3; k++) begin
      setf(4'h1);
      wait_en(1'b0, 20);
      chk_bit("irq", 1'b1, irq);
      setf(4'h0);
      repeat (30) @(posedge clk_sys_i);
      chk_bit("out_en held", 1'b0, out_en);
      rchk(ADDR_STATE, 32'h101);
      case (k)
        0: host.wr(ADDR_STATUS, 32'h1);
        1: host.wr(ADDR_CTRL, 32'h3);
        default: begin
          host.pin(1'b0, 6);
          host.pin(1'b1, 0);
        end
      endcase
      wait_en(1'b1, 20);
    end
    rchk(ADDR_STATUS, 32'h1);
    host.wr(ADDR_MASK, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    chk_bit("irq masked", 1'b0, irq);
    host.wr(ADDR_STATUS, 32'h1);
    rchk(ADDR_STATUS, 32'h0);
    // keep running for one delay unit, then latch since retry field is 0
    host.wr(ADDR_CFG0, 32'h41);
    setf(4'h1);
    wait_en(1'b0, 300);
    chk_bit("delay span", 1'b1, n inside {[200:210]});
    setf(4'h0);
    repeat (30) @(posedge clk_sys_i);
    chk_bit("latched after delay", 1'b0, out_en);
    host.wr(ADDR_STATUS, 32'h1);
    wait_en(1'b1, 20);
    // disable and retry once, then latch with one retry used
    host.wr(ADDR_CFG0, 32'h88);
    setf(4'h1);
    wait_en(1'b0, 20);
    wait_en(1'b1, 2100);
    chk_bit("retry wait", 1'b1, n inside {[1990:2010]});
    wait_en(1'b0, 20);
    rchk(ADDR_TRIES, 32'h1);
    repeat (2100) @(posedge clk_sys_i);
    chk_bit("retries spent", 1'b0, out_en);
    setf(4'h0);
    host.wr(ADDR_STATUS, 32'h1);
    rchk(ADDR_TRIES, 32'h0);
    wait_en(1'b1, 20);
    // fault 1 rides through one unit of its own, twice that of fault 0, then latches
    host.wr(8'h24, 32'h41);
    setf(4'h2);
    wait_en(1'b0, 500);
    chk_bit("unit of fault 1", 1'b1, n inside {[400:410]});
    rchk(ADDR_STATE, 32'h2_0202);
    setf(4'h0);
    host.wr(ADDR_STATUS, 32'h2);
    wait_en(1'b1, 20);
    // zero delay with endless retries: shut, resume, shut again, never latch
    host.wr(ADDR_CFG0, 32'h78);
    setf(4'h1);
    wait_en(1'b0, 20);
    wait_en(1'b1, 2100);
    chk_bit("endless retry wait", 1'b1, n inside {[1990:2010]});
    wait_en(1'b0, 20);
    rchk(ADDR_STATE, 32'h1_0001);
    rchk(ADDR_TRIES, 32'h1);
    setf(4'h0);
    host.wr(ADDR_CTRL, 32'h3);
    wait_en(1'b1, 20);
    rchk(ADDR_TRIES, 32'h0);
    // code 00 lets a fault pass with no action and no event
    host.wr(ADDR_CFG0, 32'h01);
    setf(4'h1);
    repeat (30) @(posedge clk_sys_i);
    chk_bit("ignored fault", 1'b1, out_en);
    rchk(ADDR_STATUS, 32'h0);
    setf(4'h0);
    // a device reset mid-run drops a latched fault and restores defaults
    host.wr(ADDR_CFG0, 32'hC1);
    setf(4'h1);
    wait_en(1'b0, 20);
    setf(4'h0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rchk(ADDR_STATE, 32'h0);
    rchk(ADDR_CFG0, 32'hC0);
    wait_en(1'b1, 20);
    close_out();
  end
endmodule
